// [adc_cfg_checker.sv]
/* Link checker: framing and pin drive between the two ends.
   Assumes the link signals and the shared clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic host_oe_i,
  input wire logic host_dout_i,
  input wire logic dev_oe_i,
  input wire logic readback_oe_i
);
  // One clock domain, reset masks everything
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shared pin never fought over
  a_one_driver: assert property (!(host_oe_i && dev_oe_i))
    else $error("pin contention");
  // Readback pin only with the shared pin released
  a_rb_alone: assert property (readback_oe_i |-> !dev_oe_i && !host_oe_i)
    else $error("readback overlap");
  // Idle link is quiet once select has settled
  a_idle_quiet: assert property (sel_n_i && $past(sel_n_i)
    |-> !sclk_i && !dev_oe_i && !readback_oe_i) else $error("activity while idle");
  // Setup time before the first clock
  a_lead_time: assert property ($fell(sel_n_i) |-> !sclk_i [*4])
    else $error("short lead");
  a_sclk_high: assert property ($rose(sclk_i) |-> sclk_i [*4] ##1 !sclk_i)
    else $error("bad high phase");
  a_sclk_low: assert property ($fell(sclk_i) && !sel_n_i |-> !sclk_i [*4])
    else $error("bad low phase");
  // Host data only moves while the clock is low
  a_data_hold: assert property (sclk_i && host_oe_i |-> $stable(host_dout_i))
    else $error("data moved high");
  // Device turns on its driver only after a fall
  a_dev_on_low: assert property ($rose(dev_oe_i || readback_oe_i) |-> !sclk_i)
    else $error("drive on high");
  c_read3: cover property ($rose(dev_oe_i));
  c_read4: cover property ($rose(readback_oe_i));
  c_frame: cover property ($rose(sel_n_i));
endmodule
`default_nettype wire

// [adc_cfg_dev.sv]
/*
  Device end: serial configuration slave, register bank and
  the correction, output shaping and over-range datapath the
  registers steer. Assumes serial pins synchronous to clk_i
  and a serial clock half period of at least two clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  adc_spi_if.dev spi,
  input wire logic [1:0][adc_cfg_pkg::SMP_W-1:0] sample_i,
  input wire logic chan_b_cal_kick_i,
  output wire logic [1:0][adc_cfg_pkg::SMP_W-1:0] data_o,
  output logic data_valid_o,
  output wire logic [1:0] overload_indication_o,
  output logic output_mode_select_o,
  output logic perf_tuning_bit_one_o
);
  import adc_cfg_pkg::*;

  logic sclk_q_ff; // Serial clock one cycle ago
  logic sclk_rise; // Serial clock went high
  logic sclk_fall; // Serial clock went low
  logic [CNT_W-1:0] cnt_ff; // Rising edges in this frame
  logic [DATA_BITS-1:0] sh_ff; // Incoming bits
  logic [REG_AW-1:0] addr_ff; // Frame register address
  logic rd_ff; // Frame is a readback
  logic [DATA_BITS-1:0] rd_sh_ff; // Outgoing readback word
  logic drive_ff; // Device owns an output pin
  logic dout_ff; // Bit presented on the pins
  logic [ADDR_BITS-1:0] abyte; // Address byte as it completes
  logic [DATA_BITS-1:0] wdata; // Data word as it completes
  logic wr_en; // Commit of a write frame
  logic four_ff; // Four-wire access
  logic dec_ff; // Decimation (receive) mode
  logic band_a_ff; // Channel A band select
  logic band_b_ff; // Channel B band select
  logic rate_ff; // Burst high-resolution rate
  logic trig_ff; // Stored only, no effect here
  logic corr_a_ff; // Channel A autocal enable
  logic corr_b_ff; // Channel B autocal enable
  logic fmt_ff; // Offset binary when set
  logic perf_ff; // Tuning bit, exported
  logic [THR_W-1:0] thr_ff; // Over-range threshold
  logic [DATA_BITS-1:0] kick_reg_ff; // Kick register image
  logic [1:0] phase_ff; // Output phase within four
  logic stb; // Output word this cycle

  // Readback image of one register; unmapped reads zero
  function automatic logic [DATA_BITS-1:0] reg_read(
    input logic [REG_AW-1:0] a
  );
    logic [DATA_BITS-1:0] v;
    v = '0;
    case (a)
      REG_MODE: begin
        v[B_FOUR_WIRE] = four_ff;
        v[B_DEC] = dec_ff;
        v[B_BAND_A] = band_a_ff;
        v[B_BAND_B] = band_b_ff;
        v[B_RATE] = rate_ff;
        v[B_TRIG] = trig_ff;
      end
      REG_CORR: begin
        v[B_CORR_A] = corr_a_ff;
        v[B_CORR_B] = corr_b_ff;
        v[B_FMT] = fmt_ff;
        v[B_PERF1] = perf_ff;
      end
      REG_THR: begin
        // Two fixed bits read back as one
        v[B_RB_HI] = 1'b1;
        v[B_RB_LO] = 1'b1;
        v[THR_LSB +: THR_W] = thr_ff;
      end
      REG_KICK: begin
        v = kick_reg_ff;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // Pins are synchronous, so a plain delay gives edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= spi.sclk;
    end
  end
  assign sclk_rise = spi.sclk & ~sclk_q_ff;
  assign sclk_fall = ~spi.sclk & sclk_q_ff;
  assign abyte = {sh_ff[ADDR_BITS-2:0], spi.data_pin};
  assign wdata = {sh_ff[DATA_BITS-2:0], spi.data_pin};

  // Edge count; saturates so extra clocks do nothing
  always_ff @(posedge clk_i) begin
    if (rst_i || spi.sel_n) begin
      cnt_ff <= '0;
    end else if (sclk_rise && cnt_ff != CNT_FRAME) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // Input shifter, written data taken on rising edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ff <= '0;
    end else if (sclk_rise) begin
      sh_ff <= wdata;
    end
  end

  // Address and direction latched with the eighth bit
  always_ff @(posedge clk_i) begin
    if (rst_i || spi.sel_n) begin
      rd_ff <= 1'b0;
      addr_ff <= '0;
    end else if (sclk_rise && cnt_ff == CNT_ADDR_LAST) begin
      rd_ff <= abyte[RW_BIT];
      addr_ff <= abyte[REG_AW-1:0];
    end
  end

  // Readback word shifts out on falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i || spi.sel_n) begin
      rd_sh_ff <= '0;
      dout_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (sclk_rise && cnt_ff == CNT_ADDR_LAST && abyte[RW_BIT]) begin
      rd_sh_ff <= reg_read(abyte[REG_AW-1:0]);
    end else if (sclk_fall && rd_ff && cnt_ff >= CNT_DATA_FIRST
                 && cnt_ff != CNT_FRAME) begin
      // Enabling on a fall avoids fighting the host
      drive_ff <= 1'b1;
      dout_ff <= rd_sh_ff[DATA_BITS-1];
      rd_sh_ff <= {rd_sh_ff[DATA_BITS-2:0], 1'b0};
    end
  end

  // A read frame never writes
  assign wr_en = sclk_rise && cnt_ff == CNT_WR_LAST && !rd_ff;

  // Pin choice follows the width bit
  assign spi.dev_dout = dout_ff;
  assign spi.dev_oe = drive_ff & ~four_ff;
  assign spi.readback_dout = dout_ff;
  assign spi.readback_oe = drive_ff & four_ff;

  // Mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      four_ff <= 1'b0;
      dec_ff <= 1'b0;
      band_a_ff <= 1'b0;
      band_b_ff <= 1'b0;
      rate_ff <= 1'b0;
      trig_ff <= 1'b0;
    end else if (wr_en && addr_ff == REG_MODE) begin
      four_ff <= wdata[B_FOUR_WIRE];
      dec_ff <= wdata[B_DEC];
      band_a_ff <= wdata[B_BAND_A];
      band_b_ff <= wdata[B_BAND_B];
      rate_ff <= wdata[B_RATE];
      trig_ff <= wdata[B_TRIG];
    end
  end

  // Correction and format register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_a_ff <= 1'b0;
      corr_b_ff <= 1'b0;
      fmt_ff <= 1'b0;
      perf_ff <= 1'b0;
    end else if (wr_en && addr_ff == REG_CORR) begin
      corr_a_ff <= wdata[B_CORR_A];
      corr_b_ff <= wdata[B_CORR_B];
      fmt_ff <= wdata[B_FMT];
      perf_ff <= wdata[B_PERF1];
    end
  end

  // Threshold; fixed bits ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_ff <= THR_RESET;
    end else if (wr_en && addr_ff == REG_THR) begin
      thr_ff <= wdata[THR_LSB +: THR_W];
    end
  end

  // Kick register, stored whole for readback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kick_reg_ff <= KICK_REG_RESET;
    end else if (wr_en && addr_ff == REG_KICK) begin
      kick_reg_ff <= wdata;
    end
  end

  assign output_mode_select_o = dec_ff;
  assign perf_tuning_bit_one_o = perf_ff;

  // Phase counter shared by both channels keeps them aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Output strobe: every second, every fourth or every cycle
  always_comb begin
    if (dec_ff) begin
      stb = phase_ff[0];
    end else if (rate_ff) begin
      stb = (phase_ff == 2'h3);
    end else begin
      stb = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_valid_o <= 1'b0;
    end else begin
      data_valid_o <= stb;
    end
  end

  // Per-channel correction, shaping and over-range
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic signed [SMP_W-1:0] x; // Raw sample
    logic signed [SMP_W-1:0] c; // Corrected sample
    logic signed [SMP_W-1:0] off_ff; // Offset estimate
    logic signed [SMP_W-1:0] prev_ff; // Previous corrected
    logic [SMP_W+1:0] acc_ff; // Running sum of four
    logic [SMP_W+1:0] acc_n;
    logic [SMP_W:0] sum; // Pair sum for low pass
    logic [SMP_W:0] dif; // Pair difference for high pass
    logic [SMP_W-1:0] mag; // Magnitude of raw sample
    logic [SMP_W-1:0] word; // Shaped word before format
    logic [SMP_W-1:0] out_ff; // Output word
    logic [OVR_DELAY-1:0] ovr_ff; // Over-range delay line
    logic en;
    logic kick;
    logic run;
    logic band;

    assign x = sample_i[g];
    assign en = (g == 0) ? corr_a_ff : corr_b_ff;
    assign kick = (g == 0) ? kick_reg_ff[B_KICK] : chan_b_cal_kick_i;
    assign run = en & ~kick;
    // Band only counts in receive mode
    assign band = dec_ff & ((g == 0) ? band_a_ff : band_b_ff);
    // Gain stays unity; only the offset loop is modelled
    assign c = run ? x - off_ff : x;

    // Offset loop steps one code toward the input mean
    always_ff @(posedge clk_i) begin
      if (rst_i || kick) begin
        off_ff <= '0;
      end else if (en) begin
        if (x > off_ff) begin
          off_ff <= off_ff + 12'sh001;
        end else if (x < off_ff) begin
          off_ff <= off_ff - 12'sh001;
        end
      end
    end

    assign sum = {c[SMP_W-1], c} + {prev_ff[SMP_W-1], prev_ff};
    assign dif = {c[SMP_W-1], c} - {prev_ff[SMP_W-1], prev_ff};
    assign acc_n = ((phase_ff == 2'h0) ? 14'h0000 : acc_ff) + {{2{c[SMP_W-1]}}, c};

    // History for the pair and quad filters
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prev_ff <= '0;
        acc_ff <= '0;
      end else begin
        prev_ff <= c;
        acc_ff <= acc_n;
      end
    end

    // Words stay MSB aligned so resolution is visible
    always_comb begin
      if (dec_ff) begin
        word = band ? dif[SMP_W:1] : sum[SMP_W:1];
      end else if (rate_ff) begin
        word = {acc_n[SMP_W+1:3], 1'b0};
      end else begin
        word = {c[SMP_W-1:3], 3'h0};
      end
    end

    // Format flips the sign bit for offset binary
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_ff <= '0;
      end else if (stb) begin
        out_ff <= fmt_ff ? {~word[SMP_W-1], word[SMP_W-2:0]} : word;
      end
    end
    assign data_o[g] = out_ff;

    // Shared threshold scaled to full-scale codes
    assign mag = x[SMP_W-1] ? SMP_W'(-x) : SMP_W'(x);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ovr_ff <= '0;
      end else begin
        ovr_ff <= {ovr_ff[OVR_DELAY-2:0],
                   mag >= {1'b0, thr_ff, 7'h00}};
      end
    end
    assign overload_indication_o[g] = ovr_ff[OVR_DELAY-1];
  end

endmodule
`default_nettype wire

// [adc_cfg_host.sv]
/*
  Host end: AXI4-Lite command slave and serial sequencer that
  runs one 24-bit frame per command on the converter link.
  Assumes a single-outstanding AXI4-Lite master on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_host (
  input wire logic clk_i,
  input wire logic rst_i,
  adc_spi_if.host spi,
  input wire logic [adc_cfg_pkg::AXI_AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [adc_cfg_pkg::AXI_AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  import adc_cfg_pkg::*;

  logic aw_got_ff; // Write address held
  logic w_got_ff; // Write data held
  logic [AXI_AW-1:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic do_wr; // Both halves present
  logic busy; // Frame in progress
  logic [FRAME_BITS-1:0] cmd_ff; // Address byte and data
  logic start_ff; // Launch a frame
  ser_st_e st_ff; // Sequencer state
  logic [DIV_W-1:0] div_ff; // Half period timer
  logic [CNT_W-1:0] bit_ff; // Rising edges issued
  logic [FRAME_BITS-1:0] tx_ff; // Outgoing bits
  logic [DATA_BITS-1:0] rx_ff; // Readback word
  logic sclk_ff;
  logic sel_n_ff;
  logic oe_ff;
  logic dout_ff;
  logic four_ff; // Mirror of device width bit
  logic rd;

  assign busy = (st_ff != ST_IDLE);
  assign rd = cmd_ff[FRAME_BITS-1];
  assign do_wr = aw_got_ff & w_got_ff & ~bvalid_o;
  assign awready_o = ~aw_got_ff & ~bvalid_o;
  assign wready_o = ~w_got_ff & ~bvalid_o;
  assign arready_o = ~rvalid_o;

  // Write address and data channels, taken in either order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got_ff <= 1'b1;
        awa_ff <= awaddr_i;
      end else if (do_wr) begin
        aw_got_ff <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_got_ff <= 1'b1;
        wd_ff <= wdata_i;
        ws_ff <= wstrb_i;
      end else if (do_wr) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Command commit; refused while a frame runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff <= '0;
      start_ff <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else begin
      start_ff <= 1'b0;
      if (do_wr) begin
        bvalid_o <= 1'b1;
        bresp_o <= RESP_OKAY;
        if (awa_ff == A_CMD && !busy) begin
          for (int b = 0; b < 3; b++) begin
            if (ws_ff[b]) begin
              cmd_ff[b*8 +: 8] <= wd_ff[b*8 +: 8];
            end
          end
          start_ff <= 1'b1;
        end else if (awa_ff == A_CMD || (awa_ff != A_STATUS && awa_ff != A_RDATA)) begin
          bresp_o <= RESP_SLVERR;
        end
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // Read channel; unmapped reads zero with an error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rresp_o <= RESP_OKAY;
      rdata_o <= '0;
      case (araddr_i)
        A_CMD: rdata_o <= {8'h00, cmd_ff};
        A_STATUS: rdata_o <= {30'h0, four_ff, busy};
        A_RDATA: rdata_o <= {16'h0000, rx_ff};
        default: rresp_o <= RESP_SLVERR;
      endcase
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  // Serial sequencer: data changes on falls, sampled on rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      div_ff <= '0;
      bit_ff <= '0;
      tx_ff <= '0;
      rx_ff <= '0;
      sclk_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (start_ff) begin
            st_ff <= ST_LEAD;
            sel_n_ff <= 1'b0;
            tx_ff <= cmd_ff;
            dout_ff <= cmd_ff[FRAME_BITS-1];
            oe_ff <= 1'b1;
            div_ff <= '0;
            bit_ff <= '0;
          end
        end
        ST_LEAD: begin
          div_ff <= div_ff + 4'h1;
          if (div_ff == LEAD_LAST) begin
            st_ff <= ST_SHIFT;
            div_ff <= '0;
          end
        end
        ST_SHIFT: begin
          div_ff <= div_ff + 4'h1;
          if (div_ff == HALF_LAST) begin
            div_ff <= '0;
            if (!sclk_ff) begin
              sclk_ff <= 1'b1;
              bit_ff <= bit_ff + 5'h01;
              if (rd && bit_ff >= CNT_DATA_FIRST) begin
                // Pin choice follows the width bit
                rx_ff <= {rx_ff[DATA_BITS-2:0],
                          four_ff ? spi.serial_readback_pin : spi.data_pin};
              end
            end else begin
              sclk_ff <= 1'b0;
              tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
              dout_ff <= tx_ff[FRAME_BITS-2];
              // Release the shared pin once a read frame's address is out
              oe_ff <= ~(rd && bit_ff >= CNT_DATA_FIRST);
              if (bit_ff == CNT_FRAME) begin
                st_ff <= ST_TRAIL;
                oe_ff <= 1'b0;
              end
            end
          end
        end
        ST_TRAIL: begin
          div_ff <= div_ff + 4'h1;
          if (div_ff == LEAD_LAST) begin
            st_ff <= ST_IDLE;
            sel_n_ff <= 1'b1;
            div_ff <= '0;
          end
        end
      endcase
    end
  end

  // Track the width bit from our own writes to the mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      four_ff <= 1'b0;
    end else if (st_ff == ST_TRAIL && div_ff == LEAD_LAST && !rd
                 && cmd_ff[DATA_BITS +: REG_AW] == REG_MODE) begin
      four_ff <= cmd_ff[B_FOUR_WIRE];
    end
  end

  assign spi.sclk = sclk_ff;
  assign spi.sel_n = sel_n_ff;
  assign spi.host_dout = dout_ff;
  assign spi.host_oe = oe_ff;

endmodule
`default_nettype wire

// [adc_cfg_pkg.sv]
/*
  Shared constants for both ends of the converter serial
  configuration link: frame layout, register map, field
  positions, reset values, timing and the host command map.
  Assumes a single 10 MHz system clock on both ends.
*/
package adc_cfg_pkg;
  // Sample width of each converter channel
  localparam int SMP_W = 12;
  // Frame: address byte, then data word, MSB first
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
  localparam int REG_AW = 7;
  localparam int RW_BIT = 7;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [CNT_W-1:0] CNT_WR_LAST = 5'h17;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
  // Register addresses
  localparam logic [REG_AW-1:0] REG_MODE = 7'h00;
  localparam logic [REG_AW-1:0] REG_CORR = 7'h01;
  localparam logic [REG_AW-1:0] REG_THR = 7'h02;
  localparam logic [REG_AW-1:0] REG_KICK = 7'h03;
  // Mode register fields
  localparam int B_FOUR_WIRE = 15;
  localparam int B_DEC = 14;
  localparam int B_BAND_A = 12;
  localparam int B_BAND_B = 9;
  localparam int B_RATE = 5;
  localparam int B_TRIG = 2;
  // Correction and format register fields
  localparam int B_CORR_A = 15;
  localparam int B_CORR_B = 9;
  localparam int B_FMT = 3;
  localparam int B_PERF1 = 1;
  // Threshold register fields
  localparam int B_RB_HI = 14;
  localparam int B_RB_LO = 13;
  localparam int THR_LSB = 7;
  localparam int THR_W = 4;
  localparam logic [THR_W-1:0] THR_RESET = 4'hF;
  // Kick register
  localparam int B_KICK = 14;
  localparam logic [DATA_BITS-1:0] KICK_REG_RESET = 16'h4B18;
  // Over-range: delay and full scale 2048 codes over 16 steps
  localparam int OVR_DELAY = 12;
  localparam int OVR_SCALE_SH = 7;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int TSU_NS = 25;
  localparam int TSU_CYC = (TSU_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_NS = 400;
  localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int LEAD_CYC = (TSU_CYC > HALF_CYC) ? TSU_CYC : HALF_CYC;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
  localparam logic [DIV_W-1:0] LEAD_LAST = DIV_W'(LEAD_CYC - 1);
  // Host command map over AXI4-Lite
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] A_CMD = 4'h0;
  localparam logic [AXI_AW-1:0] A_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] A_RDATA = 4'h8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FOUR = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Host serial sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LEAD = 4'h2,
    ST_SHIFT = 4'h4,
    ST_TRAIL = 4'h8
  } ser_st_e;
endpackage

// [adc_spi_if.sv]
/*
  Serial link between host controller and converter device.
  The shared data pin and the readback pin are resolved here
  from the drivers' enables; an idle pin reads as pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
interface adc_spi_if;
  logic sclk; // Serial clock, host driven
  logic sel_n; // Frame select, active low
  logic host_dout; // Host level on data pin
  logic host_oe; // Host drives data pin
  logic dev_dout; // Device level on data pin
  logic dev_oe; // Device drives data pin
  logic readback_dout; // Device level on readback pin
  logic readback_oe; // Device drives readback pin
  logic data_pin; // Resolved shared data pin
  logic serial_readback_pin; // Resolved readback pin
  // Pull-up when nobody drives
  assign data_pin = host_oe ? host_dout : (dev_oe ? dev_dout : 1'b1);
  assign serial_readback_pin = readback_oe ? readback_dout : 1'b1;
  modport dev (
    input sclk, sel_n, data_pin,
    output dev_dout, dev_oe, readback_dout, readback_oe
  );
  modport host (
    output sclk, sel_n, host_dout, host_oe,
    input data_pin, serial_readback_pin
  );
endinterface
`default_nettype wire

// [testbench.sv]
/* Bench: host end over AXI4-Lite, device end, register model.
   Assumes the package, the link interface and both end modules. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_cfg_pkg::*;
  logic clk_i = 0, rst_i = 1;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hF; // All bytes always
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, kick = 0;
  logic awready, wready, bvalid, arready, rvalid, mode, perf, dv;
  logic [1:0] bresp, rresp, ovl;
  logic [31:0] wdata = '0, rdata;
  logic [1:0][11:0] smp = '0, old, dout;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  // Register model, reset contents
  logic [15:0] exp_q [4] = '{16'h0000, 16'h0000, 16'h6780, 16'h4B18};
  // Bits each register keeps; the rest read zero, except the two fixed bits of register 2 that read one
  logic [15:0] msk [4] = '{16'hD224, 16'h820A, 16'h0780, 16'hFFFF};
  adc_spi_if spi ();
  adc_cfg_dev adc_cfg_dev_inst (.clk_i, .rst_i, .spi(spi.dev), .sample_i(smp),
    .chan_b_cal_kick_i(kick), .data_o(dout), .data_valid_o(dv), .overload_indication_o(ovl),
    .output_mode_select_o(mode), .perf_tuning_bit_one_o(perf));
  adc_cfg_host adc_cfg_host_inst (.clk_i, .rst_i, .spi(spi.host), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
    .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
    .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready));
  adc_cfg_checker adc_cfg_checker_inst (.clk_i, .rst_i, .sclk_i(spi.sclk), .sel_n_i(spi.sel_n),
    .host_oe_i(spi.host_oe), .host_dout_i(spi.host_dout), .dev_oe_i(spi.dev_oe),
    .readback_oe_i(spi.readback_oe));
  always #50 clk_i = ~clk_i;
  // Hang guard, far above the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk_i); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk_i); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge clk_i);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask
  // One serial frame; busy polled, since frame length is the host's business
  task automatic frame(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] r;
    wr(A_CMD, {8'h00, a, d});
    do rd(A_STATUS, r); while (r[STAT_BUSY]);
    rd(A_RDATA, r);
    q = r[15:0];
  endtask
  // Read frames carry random data, which must never be written
  task automatic check_all();
    logic [15:0] q;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      frame(8'h80 | 8'(i), 16'($urandom), q);
      chk("reg", i < 4 ? exp_q[i] : 16'h0000, q);
    end
    chk("mode", 16'(exp_q[0][B_DEC]), 16'(mode));
    chk("perf", 16'(exp_q[1][B_PERF1]), 16'(perf));
    rd(A_STATUS, r);
    chk("four", 16'(exp_q[0][B_FOUR_WIRE]), 16'(r[STAT_FOUR]));
  endtask
  // Output word for a steady sample with the offset loop idle
  function automatic logic [11:0] shape(input logic [11:0] s, input logic hp);
    logic [11:0] w;
    if (exp_q[0][B_DEC]) w = hp ? 12'h000 : s;
    else if (exp_q[0][B_RATE]) w = {s[11:1], 1'b0};
    else w = {s[11:3], 3'h0};
    return exp_q[1][B_FMT] ? w ^ 12'h800 : w;
  endfunction
  function automatic logic over(input logic [11:0] s, input logic [3:0] t);
    int x = $signed(s);
    return (x < 0 ? -x : x) >= int'(t) * 128;
  endfunction
  task automatic end_of_test();
    $display("samples_checked %0d bad_count %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [15:0] q, v;
    logic hp;
    int nv;
    void'($urandom(59470));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all();
    // Pass 0 in three-wire mode, pass 1 in four-wire mode
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        v = 16'($urandom);
        if (i == 0) v[B_FOUR_WIRE] = m[0];
        if (i == 1) v[B_PERF1] = 1'b1;
        if (i == 3) v = v | 16'h0B18;
        frame(8'(i), v, q);
        exp_q[i] = (v & msk[i]) | (i == 2 ? 16'h6000 : 16'h0000);
      end
      check_all();
    end
    // Over-range and shaping in a fresh mode: old result at 12 edges, new one at 13
    for (int k = 0; k < 10; k++) begin
      v = 16'($urandom);
      frame(8'h00, v, q);
      exp_q[0] = v & msk[0];
      v = 16'($urandom);
      v[B_PERF1] = 1'b1;
      frame(8'h01, v, q);
      exp_q[1] = v & msk[1];
      old = smp;
      smp <= {12'($urandom), 12'($urandom)};
      kick <= 1'($urandom);
      nv = 0;
      repeat (12) begin
        @(posedge clk_i);
        nv += int'(dv);
      end
      for (int c = 0; c < 2; c++) begin
        chk("ovl", 16'(over(old[c], exp_q[2][10:7])), 16'(ovl[c]));
      end
      @(posedge clk_i);
      chk("valid", 16'(exp_q[0][B_DEC] ? 6 : exp_q[0][B_RATE] ? 3 : 12), 16'(nv));
      for (int c = 0; c < 2; c++) begin
        chk("ovl", 16'(over(smp[c], exp_q[2][10:7])), 16'(ovl[c]));
        hp = c ? exp_q[0][B_BAND_B] : exp_q[0][B_BAND_A];
        // A running offset loop makes the word unpredictable; a kick pins it to zero
        if (!(c ? exp_q[1][B_CORR_B] & !kick : exp_q[1][B_CORR_A] & !exp_q[3][B_KICK])) begin
          chk("data", 16'(shape(smp[c], hp)), 16'(dout[c]));
        end
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
